// *** cpu_regs_flags.v ***
// Purpose: banked register set, flag word and operand address logic
// Assumes: synchronous active-low reset, inputs synchronous to CORE_CLK
// Notes:   read data and address results appear one clock after the request
`timescale 1ns/1ps
`include "cpu_regs_flags_regs.vh"

// Function
// RQ1: two banks of data, address and frame registers; bank flag picks one
// RQ2: data registers pair into two 32-bit operands; byte halves addressable
// RQ3: special register-direct pairs legal only for shift and jump classes
// RQ4: interrupt acceptance saves top four program counter bits beside flags
// RQ5: priority field holds eight levels; larger value is higher priority
// RQ6: stack select flag 0 uses interrupt pointer, 1 uses user pointer
// RQ7: maskable interrupts accepted only while interrupt enable is 1
// RQ8: overflow flag set on signed arithmetic overflow
// RQ9: sign flag set on negative result, cleared on positive
// RQ10: zero flag set when result equals zero
// RQ11: debug flag 1 requests single-step execution
// RQ12: carry flag captures add carry and subtract borrow
// RQ13: general operand addresses stay in lowest 64 Kbytes
// RQ14: special addressing reaches the full 1-Mbyte space with 20 bits
// RQ15: bit addressing selects single bits within lowest 64 Kbytes
// RQ16: stack relative adds signed 8-bit displacement, move class only
// RQ17: special absolute uses 20 bits; extended load/store and jumps only
// RQ18: special address-relative uses first address register, 20-bit displacement
// RQ19: static-base bit displacements of 8, 11 or 16 bits
// RQ20: pc relative short +2..+9, byte and word signed forms
// RQ21: single flags written directly only by flag set and clear ops
// RQ22: control registers written directly only by control class ops
// RQ23: bank change applies from the next instruction, banks untouched
module cpu_regs_flags (
    // clock and reset
    input  wire        CORE_CLK,
    input  wire        RST_B,
    // instruction context
    input  wire [2:0]  OPER_CLASS,
    input  wire [19:0] PC_IN,
    // operand read
    input  wire        RD_EN,
    input  wire [3:0]  RD_SEL,
    output reg  [31:0] RD_DATA,
    // operand write
    input  wire        WR_EN,
    input  wire [3:0]  WR_SEL,
    input  wire [31:0] WR_DATA,
    output reg         OPER_ERR,
    // control register access
    input  wire        CTL_EN,
    input  wire        CTL_WR,
    input  wire [2:0]  CTL_SEL,
    input  wire [15:0] CTL_WDATA,
    output reg  [15:0] CTL_RDATA,
    output reg         CTL_ERR,
    // flag set and clear
    input  wire        FLAG_EN,
    input  wire        FLAG_SET,
    input  wire [2:0]  FLAG_BIT,
    // arithmetic flag update
    input  wire        ALU_UPD,
    input  wire [1:0]  ALU_SIZE,
    input  wire [31:0] ALU_RESULT,
    input  wire        ALU_CARRY,
    input  wire        ALU_OVF,
    // interrupt request
    input  wire        INT_REQ,
    input  wire [2:0]  INT_LEVEL,
    output wire        INT_ACCEPT,
    output reg  [3:0]  PC_EXT,
    // status
    output wire [15:0] FLAG_WORD,
    output wire [19:0] TABLE_BASE,
    output wire        SINGLE_STEP,
    // operand address
    input  wire        ADDR_EN,
    input  wire [2:0]  ADDR_MODE,
    input  wire [1:0]  ADDR_DW,
    input  wire        ADDR_AREG,
    input  wire [19:0] ADDR_DISP,
    output reg  [19:0] ADDR_OUT,
    output reg  [2:0]  BIT_IDX,
    output reg         ADDR_VALID,
    output reg         ADDR_ERR
);

    reg  [15:0] gpr_reg [0:13];
    reg  [15:0] flag_reg;
    reg  [15:0] usp_reg;
    reg  [15:0] isp_reg;
    reg  [15:0] sb_reg;
    reg  [19:0] interrupt_table_base_reg;

    reg  [15:0] flag_next;
    reg  [31:0] rd_next;
    reg  [15:0] ctl_next;
    reg  [19:0] addr_next;
    reg  [2:0]  bit_next;
    reg         aerr_next;
    reg  [15:0] sp_sum;
    reg         wr_bad;
    reg         ctl_bad;
    integer     i;

    wire        bank     = flag_reg[`FLG_BANK];
    wire [2:0]  priority_level_field      = flag_reg[`FLG_IPL_MSB:`FLG_IPL_LSB];
    wire        pair_ok  = (OPER_CLASS == `CLS_SHIFT) || (OPER_CLASS == `CLS_JUMP);
    wire        ext_ok   = (OPER_CLASS == `CLS_EXT_LDST) || (OPER_CLASS == `CLS_JUMP);
    wire [15:0] act_sp   = flag_reg[`FLG_STACK_SEL] ? usp_reg : isp_reg; // see RQ6

    // bank-qualified index into the register array
    // bank one sits at 7..13, fourteen words hold both banks
    function [3:0] gidx;
        input       b;
        input [2:0] r;
        begin
            gidx = b ? (4'h7 + {1'b0, r}) : {1'b0, r}; // see RQ1
        end
    endfunction

    // codes that name a 32-bit pair
    function is_pair;
        input [3:0] s;
        begin
            is_pair = (s == `OPD_PAIR_LOW) || (s == `OPD_PAIR_HIGH) || (s == `OPD_ADDR_PAIR);
        end
    endfunction

    // byte displacement, sign-extended to 20 bits
    function [19:0] sext8;
        input [7:0] d;
        begin
            sext8 = {{12{d[7]}}, d};
        end
    endfunction

    // priority compare: larger level wins, I gates maskable requests
    assign INT_ACCEPT  = INT_REQ && flag_reg[`FLG_INT_EN] && (INT_LEVEL > priority_level_field); // see RQ5 see RQ7
    assign FLAG_WORD   = flag_reg;
    assign TABLE_BASE  = interrupt_table_base_reg;
    assign SINGLE_STEP = flag_reg[`FLG_DEBUG]; // see RQ11

    // operand read mux
    always @* begin
        rd_next = 32'h00000000;

        case (RD_SEL)
            `OPD_DATA_ZERO,
            `OPD_DATA_ONE,
            `OPD_DATA_TWO,
            `OPD_DATA_THREE,
            `OPD_ADDR_FIRST,
            `OPD_ADDR_SECOND,
            `OPD_FRAME_BASE: begin
                rd_next = {16'h0000, gpr_reg[gidx(bank, RD_SEL[2:0])]};
            end
            `OPD_ZERO_LOW:  rd_next = {24'h000000, gpr_reg[gidx(bank, 3'h0)][7:0]}; // see RQ2
            `OPD_ZERO_HIGH: rd_next = {24'h000000, gpr_reg[gidx(bank, 3'h0)][15:8]};
            `OPD_ONE_LOW:   rd_next = {24'h000000, gpr_reg[gidx(bank, 3'h1)][7:0]};
            `OPD_ONE_HIGH:  rd_next = {24'h000000, gpr_reg[gidx(bank, 3'h1)][15:8]};
            `OPD_PAIR_LOW:  rd_next = {gpr_reg[gidx(bank, 3'h2)], gpr_reg[gidx(bank, 3'h0)]};
            `OPD_PAIR_HIGH: rd_next = {gpr_reg[gidx(bank, 3'h3)], gpr_reg[gidx(bank, 3'h1)]};
            `OPD_ADDR_PAIR: rd_next = {gpr_reg[gidx(bank, 3'h5)], gpr_reg[gidx(bank, 3'h4)]};
            default:        rd_next = 32'h00000000;
        endcase
    end

    // legality of operand and control accesses
    always @* begin
        wr_bad = 1'b0;
        if ((RD_EN && is_pair(RD_SEL)) || (WR_EN && is_pair(WR_SEL))) begin
            wr_bad = !pair_ok; // see RQ3
        end

        if ((RD_EN && RD_SEL > `OPD_ADDR_PAIR) || (WR_EN && WR_SEL > `OPD_ADDR_PAIR)) begin
            wr_bad = 1'b1;
        end

        // a refused access only raises the error, nothing moves
        ctl_bad = CTL_EN && ((OPER_CLASS != `CLS_CONTROL) || (CTL_SEL > `CTL_FLAG_WORD)); // see RQ22
    end

    // control register read mux
    always @* begin
        ctl_next = 16'h0000;

        case (CTL_SEL)
            `CTL_TABLE_LOW:   ctl_next = interrupt_table_base_reg[15:0];
            `CTL_TABLE_HIGH:  ctl_next = {12'h000, interrupt_table_base_reg[19:16]};
            `CTL_INT_SP:      ctl_next = isp_reg;
            `CTL_USER_SP:     ctl_next = usp_reg;
            `CTL_STATIC_BASE: ctl_next = sb_reg;
            `CTL_FRAME_BASE:  ctl_next = gpr_reg[gidx(bank, 3'h6)];
            `CTL_FLAG_WORD:   ctl_next = flag_reg;
            default:          ctl_next = 16'h0000;
        endcase
    end

    // flag word next value; interrupt > flag op > control write > alu
    always @* begin
        flag_next = flag_reg;

        if (ALU_UPD) begin
            flag_next[`FLG_CARRY]    = ALU_CARRY; // see RQ12
            flag_next[`FLG_OVERFLOW] = ALU_OVF;   // see RQ8
            case (ALU_SIZE)
                `SZ_BYTE: begin
                    flag_next[`FLG_SIGN] = ALU_RESULT[7]; // see RQ9
                    flag_next[`FLG_ZERO] = (ALU_RESULT[7:0] == 8'h00); // see RQ10
                end
                `SZ_WORD: begin
                    flag_next[`FLG_SIGN] = ALU_RESULT[15];
                    flag_next[`FLG_ZERO] = (ALU_RESULT[15:0] == 16'h0000);
                end
                default: begin
                    flag_next[`FLG_SIGN] = ALU_RESULT[31];
                    flag_next[`FLG_ZERO] = (ALU_RESULT == 32'h00000000);
                end
            endcase
        end

        if (CTL_EN && CTL_WR && !ctl_bad && CTL_SEL == `CTL_FLAG_WORD) begin
            flag_next = CTL_WDATA; // see RQ22
        end

        if (FLAG_EN && OPER_CLASS == `CLS_FLAG) begin
            flag_next[FLAG_BIT] = FLAG_SET; // see RQ21
        end

        // applied last so acceptance beats a same-cycle flag write
        if (INT_ACCEPT) begin
            flag_next[`FLG_IPL_MSB:`FLG_IPL_LSB] = INT_LEVEL;
            flag_next[`FLG_INT_EN] = 1'b0;
        end
    end

    // operand address generation
    always @* begin
        addr_next = 20'h00000;
        bit_next  = 3'h0;
        aerr_next = 1'b0;
        sp_sum    = act_sp + {{8{ADDR_DISP[7]}}, ADDR_DISP[7:0]};

        case (ADDR_MODE)
            `AM_GEN_ABS: begin
                addr_next = {4'h0, ADDR_DISP[15:0]}; // see RQ13
            end
            `AM_GEN_AREL: begin
                // sum cut to 16 bits keeps the result in the low region
                addr_next = {4'h0, gpr_reg[gidx(bank, {2'b10, ADDR_AREG})] + ADDR_DISP[15:0]};
            end
            `AM_SPEC_ABS: begin
                addr_next = ADDR_DISP; // see RQ14 see RQ17
                aerr_next = !ext_ok;
            end
            `AM_SPEC_AREL: begin
                addr_next = {4'h0, gpr_reg[gidx(bank, 3'h4)]} + ADDR_DISP; // see RQ18
                aerr_next = !ext_ok;
            end
            `AM_SP_REL: begin
                addr_next = {4'h0, sp_sum}; // see RQ16
                aerr_next = (OPER_CLASS != `CLS_MOVE);
            end

            `AM_BIT_SB: begin
                // displacement counts bits, so byte reach is width minus three
                bit_next = ADDR_DISP[2:0]; // see RQ15
                case (ADDR_DW)
                    `DW_SHORT: addr_next = {4'h0, sb_reg + {11'h000, ADDR_DISP[7:3]}}; // see RQ19
                    `DW_BYTE:  addr_next = {4'h0, sb_reg + {8'h00, ADDR_DISP[10:3]}};
                    default:   addr_next = {4'h0, sb_reg + {3'h0, ADDR_DISP[15:3]}};
                endcase
            end

            `AM_PC_REL: begin
                // sums wrap at 20 bits like the counter itself
                aerr_next = (OPER_CLASS != `CLS_JUMP);
                case (ADDR_DW)
                    `DW_SHORT: addr_next = PC_IN + `SHORT_JUMP_BASE + {17'h00000, ADDR_DISP[2:0]}; // see RQ20
                    `DW_BYTE:  addr_next = PC_IN + sext8(ADDR_DISP[7:0]);
                    default:   addr_next = PC_IN + {{4{ADDR_DISP[15]}}, ADDR_DISP[15:0]};
                endcase
            end

            default: begin
                // only four bits of the second register reach the address
                addr_next = {gpr_reg[gidx(bank, 3'h5)][3:0], gpr_reg[gidx(bank, 3'h4)]}; // see RQ14
                aerr_next = (OPER_CLASS != `CLS_EXT_LDST);
            end
        endcase
    end

    // state update
    always @(posedge CORE_CLK) begin
        if (!RST_B) begin
            // all-zero reset is a local choice
            for (i = 0; i < 14; i = i + 1) begin
                gpr_reg[i] <= `RST_WORD;
            end
            flag_reg   <= `RST_WORD;
            usp_reg    <= `RST_WORD;
            isp_reg    <= `RST_WORD;
            sb_reg     <= `RST_WORD;
            interrupt_table_base_reg   <= `RST_TABLE;
            PC_EXT     <= `RST_PC_EXT;

            RD_DATA    <= 32'h00000000;
            OPER_ERR   <= 1'b0;
            CTL_RDATA  <= 16'h0000;
            CTL_ERR    <= 1'b0;
            ADDR_OUT   <= 20'h00000;
            BIT_IDX    <= 3'h0;
            ADDR_VALID <= 1'b0;
            ADDR_ERR   <= 1'b0;
        end else begin
            // bank flag is a register, so a change is seen by the next access
            flag_reg <= flag_next; // see RQ23

            // read data holds across refused reads
            if (RD_EN && !wr_bad) begin
                RD_DATA <= rd_next;
            end
            OPER_ERR <= wr_bad;

            if (WR_EN && !wr_bad) begin
                case (WR_SEL)
                    `OPD_ZERO_LOW:  gpr_reg[gidx(bank, 3'h0)][7:0]  <= WR_DATA[7:0];
                    `OPD_ZERO_HIGH: gpr_reg[gidx(bank, 3'h0)][15:8] <= WR_DATA[7:0];
                    `OPD_ONE_LOW:   gpr_reg[gidx(bank, 3'h1)][7:0]  <= WR_DATA[7:0];
                    `OPD_ONE_HIGH:  gpr_reg[gidx(bank, 3'h1)][15:8] <= WR_DATA[7:0];

                    `OPD_PAIR_LOW: begin
                        gpr_reg[gidx(bank, 3'h0)] <= WR_DATA[15:0]; // see RQ2
                        gpr_reg[gidx(bank, 3'h2)] <= WR_DATA[31:16];
                    end
                    `OPD_PAIR_HIGH: begin
                        gpr_reg[gidx(bank, 3'h1)] <= WR_DATA[15:0];
                        gpr_reg[gidx(bank, 3'h3)] <= WR_DATA[31:16];
                    end
                    `OPD_ADDR_PAIR: begin
                        gpr_reg[gidx(bank, 3'h4)] <= WR_DATA[15:0];
                        gpr_reg[gidx(bank, 3'h5)] <= WR_DATA[31:16];
                    end
                    default: gpr_reg[gidx(bank, WR_SEL[2:0])] <= WR_DATA[15:0]; // see RQ1
                endcase
            end

            CTL_ERR <= ctl_bad;
            if (CTL_EN && !ctl_bad) begin
                CTL_RDATA <= ctl_next;
            end

            if (CTL_EN && CTL_WR && !ctl_bad) begin
                case (CTL_SEL)
                    `CTL_TABLE_LOW:   interrupt_table_base_reg[15:0]  <= CTL_WDATA; // see RQ22
                    `CTL_TABLE_HIGH:  interrupt_table_base_reg[19:16] <= CTL_WDATA[3:0];
                    `CTL_INT_SP:      isp_reg <= CTL_WDATA;
                    `CTL_USER_SP:     usp_reg <= CTL_WDATA;
                    `CTL_STATIC_BASE: sb_reg  <= CTL_WDATA;
                    `CTL_FRAME_BASE:  gpr_reg[gidx(bank, 3'h6)] <= CTL_WDATA;
                    default:          sb_reg  <= sb_reg;
                endcase
            end

            if (INT_ACCEPT) begin
                PC_EXT <= PC_IN[19:16]; // see RQ4
            end

            ADDR_VALID <= ADDR_EN && !aerr_next;
            ADDR_ERR   <= ADDR_EN && aerr_next;
            if (ADDR_EN) begin
                ADDR_OUT <= addr_next;
                BIT_IDX  <= bit_next;
            end
        end
    end

endmodule

// *** cpu_regs_flags_props.sv ***
// Purpose: port checks for the register set and flag word
// Assumes: one clock, synchronous active-low reset
// Notes:   flags c0 d1 z2 s3 b4 o5 i6 u7, level in 14:12
`timescale 1ns/1ps
module cpu_regs_flags_props (
    // clock and reset
    input wire        CORE_CLK,
    input wire        RST_B,
    // requests
    input wire [2:0]  OPER_CLASS,
    input wire [19:0] PC_IN,
    input wire        RD_EN,
    input wire [3:0]  RD_SEL,
    input wire        CTL_EN,
    input wire        FLAG_EN,
    input wire        ALU_UPD,
    input wire        INT_REQ,
    input wire [2:0]  INT_LEVEL,
    input wire        ADDR_EN,
    input wire [2:0]  ADDR_MODE,
    // results
    input wire        OPER_ERR,
    input wire        CTL_ERR,
    input wire        INT_ACCEPT,
    input wire [3:0]  PC_EXT,
    input wire [15:0] FLAG_WORD,
    input wire        SINGLE_STEP,
    input wire [19:0] ADDR_OUT,
    input wire        ADDR_VALID,
    input wire        ADDR_ERR
);
    wire [3:0] pc_top = PC_IN[19:16];
    wire       pair_sel = RD_SEL == 4'hB || RD_SEL == 4'hC || RD_SEL == 4'hD;
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_B);
    a_accept_exact: assert property (
        INT_ACCEPT == (INT_REQ && FLAG_WORD[6] && INT_LEVEL > FLAG_WORD[14:12])) else $error("accept mismatch");
    a_level_taken: assert property (
        INT_ACCEPT |=> FLAG_WORD[14:12] == $past(INT_LEVEL) && !FLAG_WORD[6]) else $error("level not taken");
    a_pc_ext_saved: assert property (
        INT_ACCEPT |=> PC_EXT == $past(pc_top)) else $error("pc top bits not saved");
    a_step_debug: assert property (SINGLE_STEP == FLAG_WORD[1]) else $error("step flag mismatch");
    a_ctl_refused: assert property (
        CTL_EN && OPER_CLASS != 3'h5 |=> CTL_ERR) else $error("control access not refused");
    a_flag_class_only: assert property (
        FLAG_EN && OPER_CLASS != 3'h6 && !INT_ACCEPT && !CTL_EN && !ALU_UPD |=> $stable(FLAG_WORD))
        else $error("flag op outside flag class");
    a_pair_refused: assert property (
        RD_EN && pair_sel && OPER_CLASS != 3'h2 && OPER_CLASS != 3'h3 |=> OPER_ERR) else $error("pair not refused");
    a_gen_low_range: assert property (
        ADDR_EN && ADDR_MODE == 3'h0 |=> ADDR_VALID && ADDR_OUT[19:16] == 4'h0) else $error("general addr range");
    a_sp_rel_move: assert property (
        ADDR_EN && ADDR_MODE == 3'h4 && OPER_CLASS != 3'h1 |=> ADDR_ERR && !ADDR_VALID) else $error("sp mode class");
    a_pc_rel_jump: assert property (
        ADDR_EN && ADDR_MODE == 3'h6 && OPER_CLASS != 3'h3 |=> ADDR_ERR) else $error("pc mode class");
    c_accept: cover property (INT_ACCEPT);
    c_pair_err: cover property (RD_EN && pair_sel ##1 OPER_ERR);
    c_sp_rel: cover property (ADDR_EN && ADDR_MODE == 3'h4 ##1 ADDR_VALID);
endmodule

bind cpu_regs_flags cpu_regs_flags_props u_props (.CORE_CLK, .RST_B, .OPER_CLASS, .PC_IN, .RD_EN, .RD_SEL,
    .CTL_EN, .FLAG_EN, .ALU_UPD, .INT_REQ, .INT_LEVEL, .ADDR_EN, .ADDR_MODE, .OPER_ERR, .CTL_ERR,
    .INT_ACCEPT, .PC_EXT, .FLAG_WORD, .SINGLE_STEP, .ADDR_OUT, .ADDR_VALID, .ADDR_ERR);

// *** cpu_regs_flags_regs.vh ***
// Purpose: constants for the cpu register set and flag word
// Assumes: included by cpu_regs_flags.v only
// Notes:   operand, class and mode codes are local encodings
`ifndef CPU_REGS_FLAGS_REGS_VH
`define CPU_REGS_FLAGS_REGS_VH

// operand selector codes
`define OPD_DATA_ZERO   4'h0
`define OPD_DATA_ONE    4'h1
`define OPD_DATA_TWO    4'h2
`define OPD_DATA_THREE  4'h3
`define OPD_ADDR_FIRST  4'h4
`define OPD_ADDR_SECOND 4'h5
`define OPD_FRAME_BASE  4'h6
`define OPD_ZERO_LOW    4'h7
`define OPD_ZERO_HIGH   4'h8
`define OPD_ONE_LOW     4'h9
`define OPD_ONE_HIGH    4'hA
`define OPD_PAIR_LOW    4'hB
`define OPD_PAIR_HIGH   4'hC
`define OPD_ADDR_PAIR   4'hD

// instruction classes
`define CLS_GENERAL     3'h0
`define CLS_MOVE        3'h1
`define CLS_SHIFT       3'h2
`define CLS_JUMP        3'h3
`define CLS_EXT_LDST    3'h4
`define CLS_CONTROL     3'h5
`define CLS_FLAG        3'h6

// control register selectors
`define CTL_TABLE_LOW   3'h0
`define CTL_TABLE_HIGH  3'h1
`define CTL_INT_SP      3'h2
`define CTL_USER_SP     3'h3
`define CTL_STATIC_BASE 3'h4
`define CTL_FRAME_BASE  3'h5
`define CTL_FLAG_WORD   3'h6

// flag word bit positions
`define FLG_CARRY       0
`define FLG_DEBUG       1
`define FLG_ZERO        2
`define FLG_SIGN        3
`define FLG_BANK        4
`define FLG_OVERFLOW    5
`define FLG_INT_EN      6
`define FLG_STACK_SEL   7
`define FLG_IPL_LSB     12
`define FLG_IPL_MSB     14

// address modes
`define AM_GEN_ABS      3'h0
`define AM_GEN_AREL     3'h1
`define AM_SPEC_ABS     3'h2
`define AM_SPEC_AREL    3'h3
`define AM_SP_REL       3'h4
`define AM_BIT_SB       3'h5
`define AM_PC_REL       3'h6
`define AM_SPEC_AIND    3'h7

// operand sizes and displacement widths
`define SZ_BYTE         2'h0
`define SZ_WORD         2'h1
`define SZ_LONG         2'h2
`define DW_SHORT        2'h0
`define DW_BYTE         2'h1
`define DW_WORD         2'h2
`define SHORT_JUMP_BASE 20'h00002

// reset values
`define RST_WORD        16'h0000
`define RST_TABLE       20'h00000
`define RST_PC_EXT      4'h0

`endif

// *** tb_top.sv ***
// Purpose: self-checking bench for the register set and flag word
// Assumes: inputs move at the falling edge, results read at the next falling edge
// Notes:   a mirror of both banks and the flags predicts every operand read
`timescale 1ns/1ps
module tb_top;
    // stimulus
    logic        CORE_CLK = '0, RST_B = '0, RD_EN = '0, WR_EN = '0, CTL_EN = '0, CTL_WR = '0, FLAG_EN = '0;
    logic        FLAG_SET = '0, ALU_UPD = '0, ALU_CARRY = '0, ALU_OVF = '0, INT_REQ = '0, ADDR_EN = '0, ADDR_AREG = '0;
    logic [2:0]  OPER_CLASS = '0, CTL_SEL = '0, FLAG_BIT = '0, INT_LEVEL = '0, ADDR_MODE = '0;
    logic [1:0]  ALU_SIZE = '0, ADDR_DW = '0;
    logic [3:0]  RD_SEL = '0, WR_SEL = '0;
    logic [15:0] CTL_WDATA = '0;
    logic [19:0] PC_IN = '0, ADDR_DISP = '0;
    logic [31:0] WR_DATA = '0, ALU_RESULT = '0;
    // results
    wire         OPER_ERR, CTL_ERR, INT_ACCEPT, SINGLE_STEP, ADDR_VALID, ADDR_ERR;
    wire  [2:0]  BIT_IDX;
    wire  [3:0]  PC_EXT;
    wire  [15:0] CTL_RDATA, FLAG_WORD;
    wire  [19:0] TABLE_BASE, ADDR_OUT;
    wire  [31:0] RD_DATA;
    // mirror state
    logic [15:0] mreg [0:1][0:6] = '{default: '0};
    logic [15:0] mflg = '0;
    logic [15:0] cv [0:6] = '{16'h1234, 16'h000A, 16'h1234, 16'h8000, 16'h0100, 16'hBEEF, 16'h3040};
    int          mismatches = 0, samples_checked = 0, cycles = 0;
    logic        b0;

    cpu_regs_flags u_cpu_regs_flags (.CORE_CLK, .RST_B, .OPER_CLASS, .PC_IN, .RD_EN, .RD_SEL, .RD_DATA, .WR_EN,
        .WR_SEL, .WR_DATA, .OPER_ERR, .CTL_EN, .CTL_WR, .CTL_SEL, .CTL_WDATA, .CTL_RDATA, .CTL_ERR, .FLAG_EN,
        .FLAG_SET, .FLAG_BIT, .ALU_UPD, .ALU_SIZE, .ALU_RESULT, .ALU_CARRY, .ALU_OVF, .INT_REQ, .INT_LEVEL,
        .INT_ACCEPT, .PC_EXT, .FLAG_WORD, .TABLE_BASE, .SINGLE_STEP, .ADDR_EN, .ADDR_MODE, .ADDR_DW, .ADDR_AREG,
        .ADDR_DISP, .ADDR_OUT, .BIT_IDX, .ADDR_VALID, .ADDR_ERR);

    always #20 CORE_CLK = ~CORE_CLK;

    // hang guard, the whole run needs well under a thousand cycles
    always @(posedge CORE_CLK) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic logic [31:0] er(input logic [3:0] s);
        logic b;
        b = mflg[4];
        if (s < 4'h7) er = {16'h0000, mreg[b][s]};
        else if (s < 4'hB) er = {24'h000000, mreg[b][(s - 7) / 2][(s - 7) % 2 * 8 +: 8]};
        else er = {mreg[b][s == 4'hD ? 5 : s - 9], mreg[b][s == 4'hD ? 4 : s - 11]};
    endfunction

    task automatic rw(input logic w, input logic [3:0] s, input logic [31:0] d, input logic [2:0] c);
        @(negedge CORE_CLK);
        {OPER_CLASS, WR_EN, RD_EN, WR_SEL, RD_SEL, WR_DATA} = {c, w, !w, s, s, d};
        @(negedge CORE_CLK);
        {WR_EN, RD_EN} = 2'h0;
    endtask

    task automatic mw(input logic [3:0] s, input logic [31:0] d);
        logic b;
        b = mflg[4];
        rw(1'b1, s, d, 3'h2);
        if (s < 4'h7) mreg[b][s] = d[15:0];
        else if (s < 4'hB) mreg[b][(s - 7) / 2][(s - 7) % 2 * 8 +: 8] = d[7:0];
        else {mreg[b][s == 4'hD ? 5 : s - 9], mreg[b][s == 4'hD ? 4 : s - 11]} = d;
    endtask

    task automatic rdc(input logic [3:0] s, input logic [2:0] c);
        logic ill;
        ill = s > 4'hA && c != 3'h2 && c != 3'h3;
        rw(1'b0, s, '0, c);
        chk("oper_err", OPER_ERR, ill);
        if (!ill) chk("rd", RD_DATA & (s < 4'h7 ? 32'hFFFF : s < 4'hB ? 32'hFF : 32'hFFFFFFFF), er(s));
    endtask

    task automatic flag_word(input logic st, input logic [2:0] bt, input logic [2:0] c);
        @(negedge CORE_CLK);
        {OPER_CLASS, FLAG_SET, FLAG_BIT, FLAG_EN} = {c, st, bt, 1'b1};
        @(negedge CORE_CLK);
        FLAG_EN = 1'b0;
        if (c == 3'h6) mflg[bt] = st;
        chk("flags", FLAG_WORD, mflg);
    endtask

    task automatic ctl(input logic w, input logic [2:0] s, input logic [15:0] d, input logic [2:0] c);
        @(negedge CORE_CLK);
        {OPER_CLASS, CTL_WR, CTL_SEL, CTL_WDATA, CTL_EN} = {c, w, s, d, 1'b1};
        @(negedge CORE_CLK);
        CTL_EN = 1'b0;
        chk("ctl_err", CTL_ERR, c != 3'h5 || s == 3'h7);
    endtask

    task automatic alu(input logic [1:0] z, input logic [31:0] r, input logic cy, input logic ov);
        @(negedge CORE_CLK);
        {ALU_SIZE, ALU_RESULT, ALU_CARRY, ALU_OVF, ALU_UPD} = {z, r, cy, ov, 1'b1};
        @(negedge CORE_CLK);
        ALU_UPD = 1'b0;
        mflg[0] = cy;
        mflg[5] = ov;
        mflg[2] = (z == 2'h0 ? r[7:0] == 8'h00 : z == 2'h1 ? r[15:0] == 16'h0000 : r == 32'h00000000);
        mflg[3] = z == 2'h0 ? r[7] : z == 2'h1 ? r[15] : r[31];
        chk("alu_flags", FLAG_WORD, mflg);
    endtask

    task automatic irq(input logic [2:0] lv, input logic ex);
        @(negedge CORE_CLK);
        {INT_LEVEL, INT_REQ} = {lv, 1'b1};
        #1 chk("accept", INT_ACCEPT, ex);
        @(negedge CORE_CLK);
        INT_REQ = 1'b0;
        if (ex) {mflg[14:12], mflg[6]} = {lv, 1'b0};
        if (ex) chk("pc_ext", PC_EXT, PC_IN[19:16]);
        chk("flags", FLAG_WORD, mflg);
    endtask

    task automatic adr(input logic [2:0] md, input logic [1:0] dw, input logic [19:0] dp, input logic [2:0] c,
                       input logic [19:0] ex, input logic bad);
        @(negedge CORE_CLK);
        {OPER_CLASS, ADDR_MODE, ADDR_DW, ADDR_DISP, ADDR_EN} = {c, md, dw, dp, 1'b1};
        @(negedge CORE_CLK);
        ADDR_EN = 1'b0;
        chk("addr_err", {ADDR_ERR, ADDR_VALID}, {bad, !bad});
        if (!bad) chk("addr", ADDR_OUT, ex);
    endtask

    initial begin
        b0 = 1'($urandom(87189));
        repeat (5) @(negedge CORE_CLK);
        RST_B = 1'b1;
        chk("rst", {PC_EXT, FLAG_WORD}, '0);
        chk("rst_table", TABLE_BASE, '0);
        irq(3'h7, 1'b0);
        // random writes and reads, bank flipped now and then
        for (int i = 0; i < 40; i++) begin
            if (i % 5 == 4) flag_word(i % 10 == 4, 3'h4, 3'h6);
            mw(4'($urandom % 14), $urandom);
            rdc(4'($urandom % 14), 3'($urandom % 7));
        end
        rw(1'b1, 4'hB, 32'hDEADBEEF, 3'h0);
        chk("pair_wr_err", OPER_ERR, 1'b1);
        for (int k = 0; k < 28; k++) begin
            if (k == 14) flag_word(!mflg[4], 3'h4, 3'h6);
            rdc(4'(k % 14), 3'h3);
        end
        flag_word(1'b1, 3'h1, 3'h0);
        flag_word(1'b1, 3'h1, 3'h6);
        chk("step", SINGLE_STEP, 1'b1);
        flag_word(1'b0, 3'h1, 3'h6);
        alu(2'h2, '0, 1'b1, 1'b0);
        for (int i = 0; i < 24; i++) alu(2'($urandom % 3), i % 4 ? $urandom : 32'hFF000000, 1'($urandom), 1'($urandom));
        b0 = mflg[4];
        for (int s = 0; s < 7; s++) begin
            ctl(1'b1, 3'(s), cv[s], 3'h5);
            ctl(1'b0, 3'(s), '0, 3'h5);
            chk("ctl_rd", CTL_RDATA & (s == 1 ? 16'h000F : 16'hFFFF), cv[s]);
        end
        mreg[b0][6] = cv[5];
        mflg = cv[6];
        chk("table", TABLE_BASE, 20'hA1234);
        rdc(4'h6, 3'h0);
        ctl(1'b1, 3'h3, 16'hFFFF, 3'h0);
        ctl(1'b0, 3'h3, '0, 3'h5);
        chk("usp_kept", CTL_RDATA, cv[3]);
        ctl(1'b0, 3'h7, '0, 3'h5);
        PC_IN = 20'h12345;
        irq(3'h3, 1'b0);
        irq(3'h5, 1'b1);
        irq(3'h7, 1'b0);
        adr(3'h4, 2'h0, 20'h000FF, 3'h1, 20'h01233, 1'b0);
        adr(3'h4, 2'h0, 20'h000FF, 3'h0, '0, 1'b1);
        adr(3'h0, 2'h0, 20'h1ABCD, 3'h0, 20'h0ABCD, 1'b0);
        adr(3'h2, 2'h0, 20'hFFFFF, 3'h4, 20'hFFFFF, 1'b0);
        adr(3'h2, 2'h0, 20'hFFFFF, 3'h0, '0, 1'b1);
        adr(3'h3, 2'h0, 20'hF0000, 3'h3, 20'hF0000 + mreg[0][4], 1'b0);
        adr(3'h5, 2'h2, 20'h00013, 3'h0, 20'h00102, 1'b0);
        chk("bit_idx", BIT_IDX, 3'h3);
        adr(3'h6, 2'h0, 20'h00007, 3'h3, 20'h1234E, 1'b0);
        adr(3'h6, 2'h1, 20'h00080, 3'h3, 20'h122C5, 1'b0);
        adr(3'h6, 2'h2, 20'h08000, 3'h3, 20'h0A345, 1'b0);
        adr(3'h6, 2'h0, 20'h00000, 3'h1, '0, 1'b1);
        flag_word(1'b1, 3'h7, 3'h6);
        adr(3'h4, 2'h0, 20'h0007F, 3'h1, 20'h0807F, 1'b0);
        ADDR_AREG = 1'b1;
        adr(3'h1, 2'h0, 20'h0FFFF, 3'h0, {4'h0, mreg[mflg[4]][5] - 16'h0001}, 1'b0);
        adr(3'h7, 2'h0, '0, 3'h4, {mreg[mflg[4]][5][3:0], mreg[mflg[4]][4]}, 1'b0);
        adr(3'h7, 2'h0, '0, 3'h0, '0, 1'b1);
        wrap_up();
    end
endmodule
